// >>> src/afs_top.v
// Alarm and fault summary: traffic, functional and rate alarms, lamps,
// module fault LEDs, audible alarm, pushbuttons and activity scanners.
// Assumes all inputs but the two pushbuttons are synchronous to pclk; panel parts are outside.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "afs_regs.vh"
module afs_top #(
  parameter FUNC_DLY_CYC  = `AFS_FUNC_DLY_MS * (`AFS_NS_PER_MS /
                            `AFS_CLK_PERIOD_NS),
  parameter TRF_DLY_CYC   = `AFS_TRF_DLY_MS * (`AFS_NS_PER_MS /
                            `AFS_CLK_PERIOD_NS),
  parameter DEB_CYC       = `AFS_DEB_MS * (`AFS_NS_PER_MS /
                            `AFS_CLK_PERIOD_NS),
  parameter STALL_CYC     = `AFS_STALL_MS * (`AFS_NS_PER_MS /
                            `AFS_CLK_PERIOD_NS),
  parameter FLASH_CYC     = `AFS_FLASH_MS * (`AFS_NS_PER_MS /
                            `AFS_CLK_PERIOD_NS)
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        conditioned_diphase_active,
  input  wire [3:0]  module_fault_req,
  input  wire [13:0] scan_points,
  input  wire [35:0] rate_switch_code,
  input  wire        ack_test_button,
  input  wire        assign_button,
  output reg         traffic_fault_lamp,
  output reg         functional_fault_lamp,
  output reg         rate_overload_lamp,
  output reg  [3:0]  module_fault_led,
  output reg         audible_alarm,
  output reg  [35:0] assigned_rate_code,
  output reg         channel_assign
);

  // Rate in units of 0.6 kb/s; open circuit reads as off
  function [4:0] rate_units;
    input [2:0] code;
    begin
      case (code)
        `AFS_CODE_TTY: rate_units = 5'h02;
        `AFS_CODE_R06: rate_units = 5'h01;
        `AFS_CODE_R12: rate_units = 5'h02;
        `AFS_CODE_R24: rate_units = 5'h04;
        `AFS_CODE_R48: rate_units = 5'h08;
        `AFS_CODE_R96: rate_units = 5'h10;
        default:       rate_units = 5'h00;
      endcase
    end
  endfunction

  function fsk_ok;
    input [2:0] code;
    begin
      fsk_ok = (code == `AFS_CODE_OFF) || (code == `AFS_CODE_TTY) ||
               (code == `AFS_CODE_OPEN);
    end
  endfunction

  // Pushbuttons: sync, debounce, rising edge
  reg  [1:0]  ack_sync_reg;
  reg  [1:0]  asg_sync_reg;
  reg  [23:0] ack_deb_reg;
  reg  [23:0] asg_deb_reg;
  reg         ack_level_reg;
  reg         asg_level_reg;
  reg         ack_press_reg;
  reg         asg_press_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_sync_reg  <= 2'h0;
      asg_sync_reg  <= 2'h0;
      ack_deb_reg   <= 24'h000000;
      asg_deb_reg   <= 24'h000000;
      ack_level_reg <= 1'b0;
      asg_level_reg <= 1'b0;
      ack_press_reg <= 1'b0;
      asg_press_reg <= 1'b0;
    end else begin
      ack_sync_reg  <= {ack_sync_reg[0], ack_test_button};
      asg_sync_reg  <= {asg_sync_reg[0], assign_button};
      ack_press_reg <= 1'b0;
      asg_press_reg <= 1'b0;
      // Level must hold steady for the debounce time to be accepted
      if (ack_sync_reg[1] == ack_level_reg) begin
        ack_deb_reg <= 24'h000000;
      end else if (ack_deb_reg == DEB_CYC[23:0]) begin
        ack_deb_reg   <= 24'h000000;
        ack_level_reg <= ack_sync_reg[1];
        ack_press_reg <= ack_sync_reg[1];
      end else begin
        ack_deb_reg <= ack_deb_reg + 24'h000001;
      end
      if (asg_sync_reg[1] == asg_level_reg) begin
        asg_deb_reg <= 24'h000000;
      end else if (asg_deb_reg == DEB_CYC[23:0]) begin
        asg_deb_reg   <= 24'h000000;
        asg_level_reg <= asg_sync_reg[1];
        asg_press_reg <= asg_sync_reg[1];
      end else begin
        asg_deb_reg <= asg_deb_reg + 24'h000001;
      end
    end
  end

  // Registers written by software; fs_state carries the alarm sequence state
  reg         ctrl_alarm_en_reg;
  reg  [11:0] fsk_mask_reg;
  wire [3:0]  fs_state;

  // Activity scanners
  reg  [2:0]  scan_sel_reg   [0:`AFS_NSCAN-1];
  reg  [19:0] scan_idle_reg  [0:`AFS_NSCAN-1];
  reg         scan_prev_reg  [0:`AFS_NSCAN-1];
  wire [`AFS_NSCAN-1:0] scan_stalled;
  wire [`AFS_NSCAN-1:0] scan_wrap;
  wire        scan_step = ack_press_reg && (fs_state == `AFS_FS_SILENT);

  genvar g;
  generate
    for (g = 0; g < `AFS_NSCAN; g = g + 1) begin : g_scan
      wire [7:0] mux_in = {1'b0, scan_points[g*7 +: 7]};
      wire       point  = mux_in[scan_sel_reg[g]];
      // Spare eighth input always passes so the scan wraps
      wire       act    = (point != scan_prev_reg[g]) ||
                          (scan_sel_reg[g] == `AFS_SEL_SPARE);
      assign scan_stalled[g] = (scan_idle_reg[g] == STALL_CYC[19:0]);
      assign scan_wrap[g]    = act &&
                               (scan_sel_reg[g] == `AFS_SEL_SPARE);
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          scan_sel_reg[g]  <= 3'h0;
          scan_idle_reg[g] <= 20'h00000;
          scan_prev_reg[g] <= 1'b0;
        end else begin
          scan_prev_reg[g] <= point;
          if (scan_step || act) begin
            scan_sel_reg[g]  <= scan_sel_reg[g] + 3'h1;
            scan_idle_reg[g] <= 20'h00000;
          end else if (!scan_stalled[g]) begin
            scan_idle_reg[g] <= scan_idle_reg[g] + 20'h00001;
          end
        end
      end
    end
  endgenerate

  // Module fault confirmation: fault must persist for the full delay
  reg  [27:0] mod_cnt_reg [0:`AFS_NMOD-1];
  reg  [`AFS_NMOD-1:0] mod_conf_reg;
  wire [`AFS_NMOD-1:0] mod_raw;

  generate
    for (g = 0; g < `AFS_NMOD; g = g + 1) begin : g_mod
      if (g == `AFS_MOD_CPB) begin : g_cpb
        assign mod_raw[g] = module_fault_req[g] | (|scan_stalled);
      end else begin : g_oth
        assign mod_raw[g] = module_fault_req[g];
      end
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mod_cnt_reg[g]  <= 28'h0000000;
          mod_conf_reg[g] <= 1'b0;
        end else if (!mod_raw[g]) begin
          mod_cnt_reg[g]  <= 28'h0000000;
          mod_conf_reg[g] <= 1'b0;
        end else if (mod_cnt_reg[g] == FUNC_DLY_CYC[27:0]) begin
          mod_conf_reg[g] <= 1'b1;
        end else begin
          mod_cnt_reg[g] <= mod_cnt_reg[g] + 28'h0000001;
        end
      end
    end
  endgenerate

  wire any_conf = |mod_conf_reg;
  wire any_raw  = |mod_raw;

  // Traffic monitor with false-alarm delay
  reg  [27:0] trf_cnt_reg;
  reg         trf_fail_reg;
  reg         trf_sil_reg;
  reg         trf_resound_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trf_cnt_reg     <= 28'h0000000;
      trf_fail_reg    <= 1'b0;
      trf_sil_reg     <= 1'b0;
      trf_resound_reg <= 1'b0;
    end else begin
      if (conditioned_diphase_active) begin
        trf_cnt_reg  <= 28'h0000000;
        trf_fail_reg <= 1'b0;
      end else if (trf_cnt_reg == TRF_DLY_CYC[27:0]) begin
        trf_fail_reg <= 1'b1;
      end else begin
        trf_cnt_reg <= trf_cnt_reg + 28'h0000001;
      end
      if (trf_fail_reg && conditioned_diphase_active) begin
        // Restore after an acknowledge sounds again; set beats the ack
        trf_resound_reg <= trf_sil_reg;
        trf_sil_reg     <= 1'b0;
      end else begin
        if (ack_press_reg && trf_fail_reg) begin
          trf_sil_reg <= 1'b1;
        end
        if (ack_press_reg) begin
          trf_resound_reg <= 1'b0;
        end
      end
    end
  end

  // Functional alarm sequence
  reg  [3:0] fs_reg;
  reg  [3:0] fs_next;
  reg        func_mem_reg;
  assign fs_state = fs_reg;

  always @* begin
    case (fs_reg)
      `AFS_FS_IDLE:
        fs_next = any_conf ? `AFS_FS_SOUND : `AFS_FS_IDLE;
      // A re-stall drops confirmation though the fault stays raised
      `AFS_FS_SOUND:
        fs_next = !any_raw ? `AFS_FS_IDLE :
                  ack_press_reg ? `AFS_FS_SILENT : `AFS_FS_SOUND;
      `AFS_FS_SILENT:
        fs_next = !any_raw ? `AFS_FS_IDLE :
                  ack_press_reg ? `AFS_FS_RESCAN : `AFS_FS_SILENT;
      `AFS_FS_RESCAN:
        // A wrap of either scanner with no halt and no fault raised means the fault is gone
        fs_next = (|scan_stalled) ? `AFS_FS_SOUND :
                  ((|scan_wrap) && !any_raw) ? `AFS_FS_IDLE :
                  `AFS_FS_RESCAN;
      default:
        fs_next = `AFS_FS_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_reg       <= `AFS_FS_IDLE;
      func_mem_reg <= 1'b0;
    end else begin
      fs_reg <= fs_next;
      if (any_conf) begin
        func_mem_reg <= 1'b1;
      end else if (fs_next == `AFS_FS_IDLE) begin
        func_mem_reg <= 1'b0;
      end
    end
  end

  // Rate checking and channel assignment
  reg  [7:0]  rate_sum;
  reg  [11:0] fsk_bad;
  integer     i;

  always @* begin
    rate_sum = 8'h00;
    fsk_bad  = 12'h000;
    for (i = 0; i < `AFS_NCH; i = i + 1) begin
      rate_sum = rate_sum + {3'h0, rate_units(rate_switch_code[i*3 +: 3])};
      fsk_bad[i] = fsk_mask_reg[i] &&
                   !fsk_ok(rate_switch_code[i*3 +: 3]);
    end
  end

  wire overload  = (rate_sum > `AFS_RATE_LIMIT);
  wire fsk_inval = |fsk_bad;

  reg [25:0] flash_cnt_reg;
  reg        flash_reg;
  reg [7:0]  assign_cnt_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cnt_reg      <= 26'h0000000;
      flash_reg          <= 1'b0;
      assigned_rate_code <= 36'h000000000;
      channel_assign     <= 1'b0;
      assign_cnt_reg     <= 8'h00;
    end else begin
      if (flash_cnt_reg == FLASH_CYC[25:0]) begin
        flash_cnt_reg <= 26'h0000000;
        flash_reg     <= ~flash_reg;
      end else begin
        flash_cnt_reg <= flash_cnt_reg + 26'h0000001;
      end
      // Programming is inhibited while the rates are not acceptable
      channel_assign <= asg_press_reg && !overload && !fsk_inval;
      if (asg_press_reg && !overload && !fsk_inval) begin
        assigned_rate_code <= rate_switch_code;
        assign_cnt_reg     <= assign_cnt_reg + 8'h01;
      end
    end
  end

  // Outputs
  wire no_fault  = !trf_fail_reg && !func_mem_reg && !any_conf &&
                   !overload && !fsk_inval;
  wire lamp_test = ack_level_reg && no_fault;
  wire snd = ctrl_alarm_en_reg &&
             ((trf_fail_reg && !trf_sil_reg) || trf_resound_reg ||
              (fs_reg == `AFS_FS_SOUND));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      traffic_fault_lamp    <= 1'b0;
      functional_fault_lamp <= 1'b0;
      rate_overload_lamp    <= 1'b0;
      module_fault_led      <= 4'h0;
      audible_alarm         <= 1'b0;
    end else begin
      traffic_fault_lamp    <= trf_fail_reg || lamp_test;
      functional_fault_lamp <= (func_mem_reg && !trf_fail_reg) ||
                               lamp_test;
      rate_overload_lamp    <= overload || (fsk_inval && flash_reg) ||
                               lamp_test;
      module_fault_led      <= mod_conf_reg | {4{lamp_test}};
      audible_alarm         <= snd;
    end
  end

  // APB slave: zero wait states, unmapped addresses give pslverr
  wire wr_en = psel && penable && pwrite;
  reg  hit;
  always @* begin
    case (paddr)
      `AFS_ADDR_CTRL, `AFS_ADDR_FSK, `AFS_ADDR_STATUS,
      `AFS_ADDR_RATE, `AFS_ADDR_SCAN: hit = 1'b1;
      default:                        hit = 1'b0;
    endcase
  end
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_alarm_en_reg <= `AFS_CTRL_RST;
      fsk_mask_reg      <= `AFS_FSK_RST;
    end else if (wr_en) begin
      if (paddr == `AFS_ADDR_CTRL) begin
        ctrl_alarm_en_reg <= pwdata[0];
      end
      if (paddr == `AFS_ADDR_FSK) begin
        fsk_mask_reg <= pwdata[11:0];
      end
    end
  end

  always @* begin
    case (paddr)
      `AFS_ADDR_CTRL:   prdata = {31'h0, ctrl_alarm_en_reg};
      `AFS_ADDR_FSK:    prdata = {20'h0, fsk_mask_reg};
      `AFS_ADDR_STATUS: prdata = {16'h0000, fs_reg, mod_conf_reg,
                                  trf_resound_reg, trf_sil_reg,
                                  trf_fail_reg, func_mem_reg,
                                  audible_alarm, rate_overload_lamp,
                                  functional_fault_lamp,
                                  traffic_fault_lamp};
      `AFS_ADDR_RATE:   prdata = {assign_cnt_reg, 2'h0, fsk_bad,
                                  fsk_inval, overload, rate_sum};
      `AFS_ADDR_SCAN:   prdata = {24'h0, scan_stalled, scan_sel_reg[1],
                                  scan_sel_reg[0]};
      default:          prdata = 32'h00000000;
    endcase
  end

endmodule

// >>> src/afs_regs.vh
// Constants for the alarm and fault summary block.
// Assumes a 125 MHz pclk and a 32-bit APB register bus.
`ifndef AFS_REGS_VH
`define AFS_REGS_VH
`define AFS_CLK_PERIOD_NS 8
`define AFS_NS_PER_MS     1000000
`define AFS_FUNC_DLY_MS   2000
`define AFS_TRF_DLY_MS    100
`define AFS_DEB_MS        10
`define AFS_STALL_MS      1
`define AFS_FLASH_MS      250
`define AFS_NMOD          4
`define AFS_NCH           12
`define AFS_NSCAN         2
`define AFS_MOD_CPB       2
`define AFS_RATE_LIMIT    8'h32
`define AFS_CODE_OFF      3'h2
`define AFS_CODE_TTY      3'h0
`define AFS_CODE_R06      3'h3
`define AFS_CODE_R12      3'h1
`define AFS_CODE_R24      3'h5
`define AFS_CODE_R48      3'h4
`define AFS_CODE_R96      3'h6
`define AFS_CODE_OPEN     3'h7
`define AFS_SEL_SPARE     3'h7
`define AFS_ADDR_CTRL     12'h000
`define AFS_ADDR_FSK      12'h004
`define AFS_ADDR_STATUS   12'h008
`define AFS_ADDR_RATE     12'h00C
`define AFS_ADDR_SCAN     12'h010
`define AFS_CTRL_RST      1'h1
`define AFS_FSK_RST       12'h000
`define AFS_FS_IDLE       4'h1
`define AFS_FS_SOUND      4'h2
`define AFS_FS_SILENT     4'h4
`define AFS_FS_RESCAN     4'h8
`endif

// >>> testbench/afs_props.sv
// Concurrent checks on the alarm and fault summary ports.
// Assumes one pclk domain and the delay parameters of the design.
`timescale 1ns/10ps
module afs_props #(
  parameter TRF_DLY_CYC  = 10,
  parameter FUNC_DLY_CYC = 20
) (
  input wire        pclk,
  input wire        presetn,
  input wire        conditioned_diphase_active,
  input wire [3:0]  module_fault_req,
  input wire        ack_test_button,
  input wire [35:0] rate_switch_code,
  input wire        traffic_fault_lamp,
  input wire        functional_fault_lamp,
  input wire        rate_overload_lamp,
  input wire [3:0]  module_fault_led,
  input wire        audible_alarm,
  input wire [35:0] assigned_rate_code,
  input wire        channel_assign
);
  int lo_cnt;
  int flt_cnt;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Saturating counts, so a long fault cannot wrap them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_cnt  <= 0;
      flt_cnt <= 0;
    end else begin
      lo_cnt  <= conditioned_diphase_active ? 0 : lo_cnt + (lo_cnt < 999);
      flt_cnt <= !module_fault_req[0] ? 0 : flt_cnt + (flt_cnt < 999);
    end
  end
  sequence s_asg_once;
    channel_assign ##1 !channel_assign;
  endsequence
  // Lamp test lights the rate lamp too, which tells it apart
  traffic_delay_a: assert property (
    $rose(traffic_fault_lamp) && !rate_overload_lamp |->
    lo_cnt >= TRF_DLY_CYC) else $error("traffic lamp came early");
  traffic_alarm_a: assert property (
    lo_cnt == TRF_DLY_CYC + 5 |-> traffic_fault_lamp && audible_alarm)
    else $error("traffic failure not shown");
  traffic_over_a: assert property (
    traffic_fault_lamp && !rate_overload_lamp ##1 traffic_fault_lamp
    |-> !functional_fault_lamp) else $error("both fault lamps lit");
  func_delay_a: assert property (
    $rose(module_fault_led[0]) && !rate_overload_lamp |->
    flt_cnt >= FUNC_DLY_CYC) else $error("module fault led came early");
  led_clear_a: assert property (
    $fell(module_fault_req[0]) && !ack_test_button |->
    ##[1:3] !module_fault_led[0]) else $error("module led stuck on");
  no_rate_sound_a: assert property (
    $rose(audible_alarm) |-> traffic_fault_lamp || functional_fault_lamp
    || module_fault_led != 4'h0 || $past(traffic_fault_lamp)
    || $past(traffic_fault_lamp, 2)) else $error("alarm without fault");
  assign_only_a: assert property (
    assigned_rate_code != $past(assigned_rate_code) |-> channel_assign)
    else $error("codes changed without assign");
  assign_pulse_a: assert property (
    $rose(channel_assign) |-> s_asg_once) else $error("assign not a pulse");
  assign_take_a: assert property (
    channel_assign |-> assigned_rate_code == $past(rate_switch_code))
    else $error("assigned codes differ from switches");
endmodule
bind afs_top afs_props #(
  .TRF_DLY_CYC(TRF_DLY_CYC),
  .FUNC_DLY_CYC(FUNC_DLY_CYC)
) afs_props_i (
  .pclk, .presetn, .conditioned_diphase_active, .module_fault_req,
  .ack_test_button, .rate_switch_code, .traffic_fault_lamp,
  .functional_fault_lamp, .rate_overload_lamp, .module_fault_led,
  .audible_alarm, .assigned_rate_code, .channel_assign
);

// >>> testbench/afs_panel.sv
// Front panel model: held pushbutton presses and the rate switches.
// Assumes single-cycle press requests from the bench on pclk.
`timescale 1ns/10ps
module afs_panel (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ack_req,
  input  wire        asg_req,
  input  wire [5:0]  hold_len,
  input  wire [35:0] rate_cfg,
  output reg         ack_test_button,
  output reg         assign_button,
  output wire [35:0] rate_switch_code,
  output wire        busy
);
  reg [6:0] cnt_reg;
  assign busy = cnt_reg != 7'h00;
  // Switch codes pass straight through from rate_cfg; the bench dials unused channels off (code 2)
  assign rate_switch_code = rate_cfg;
  // Release lasts long enough to debounce before the next press
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg         <= 7'h00;
      ack_test_button <= 1'b0;
      assign_button   <= 1'b0;
    end else if (!busy && (ack_req || asg_req)) begin
      cnt_reg         <= {1'b0, hold_len} + 7'h10;
      ack_test_button <= ack_req;
      assign_button   <= asg_req;
    end else if (busy) begin
      cnt_reg <= cnt_reg - 7'h01;
      if (cnt_reg == 7'h11) begin
        ack_test_button <= 1'b0;
        assign_button   <= 1'b0;
      end
    end
  end
endmodule

// >>> testbench/afs_tb_top.sv
// Self-checking bench for afs_top with short delay parameters.
// Assumes afs_panel on the far side and afs_props bound to the top.
`timescale 1ns/10ps
`include "afs_regs.vh"
module afs_tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic        err, frz = 0, trf = 1, ack_req = 0, asg_req = 0;
  logic [3:0]  fault = 0;
  logic [13:0] scan = 0;
  logic [5:0]  hold_len = 8;
  logic [35:0] cfg = 36'h492492492;
  logic [2:0]  sel;
  logic [1:0]  fl;
  wire  [31:0] prdata;
  wire         pready, pslverr, trf_lamp, fn_lamp, rate_lamp, alarm;
  wire         asg_p, ack_b, asg_b, busy;
  wire  [3:0]  led;
  wire  [35:0] code_sw, code_asg;
  int          n_mismatch = 0, n_checks = 0, cyc = 0, n_asg = 0, k, i;
  afs_top #(.FUNC_DLY_CYC(20), .TRF_DLY_CYC(10), .DEB_CYC(3),
    .STALL_CYC(16), .FLASH_CYC(8)) afs_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .conditioned_diphase_active(trf), .module_fault_req(fault),
    .scan_points(scan), .rate_switch_code(code_sw),
    .ack_test_button(ack_b), .assign_button(asg_b),
    .traffic_fault_lamp(trf_lamp), .functional_fault_lamp(fn_lamp),
    .rate_overload_lamp(rate_lamp), .module_fault_led(led),
    .audible_alarm(alarm), .assigned_rate_code(code_asg),
    .channel_assign(asg_p));
  afs_panel afs_panel_i (.pclk(pclk), .presetn(presetn),
    .ack_req(ack_req), .asg_req(asg_req), .hold_len(hold_len),
    .rate_cfg(cfg), .ack_test_button(ack_b), .assign_button(asg_b),
    .rate_switch_code(code_sw), .busy(busy));
  always #4 pclk = ~pclk;
  // Scanner 1 points always toggle and scanner 0 points only while not frozen, so only scanner 0 can stall
  always @(posedge pclk) scan <= scan ^ {7'h7F, frz ? 7'h00 : 7'h7F};
  always @(posedge pclk) if (asg_p === 1'b1) n_asg <= n_asg + 1;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input [63:0] seen, input [63:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function logic pick(input int s);
    return s == 0 ? alarm : s == 1 ? trf_lamp : fn_lamp;
  endfunction
  task wait_on(input int s, input logic v, input int lim, input string w);
    for (i = 0; i < lim && pick(s) !== v; i++) @(posedge pclk);
    chk(pick(s), v, w);
  endtask
  task press(input logic a, input logic [5:0] len, input int mid);
    for (i = 0; i < 200 && busy !== 1'b0; i++) @(posedge pclk);
    ack_req <= a;
    asg_req <= !a;
    hold_len <= len;
    @(posedge pclk);
    ack_req <= 0;
    asg_req <= 0;
    repeat (mid) @(posedge pclk);
  endtask
  task t_regs;
    apb(0, `AFS_ADDR_CTRL, 0);
    chk(rd, 32'h1, "ctrl");
    apb(0, `AFS_ADDR_FSK, 0);
    chk(rd, 32'h0, "fsk mask");
    apb(1, `AFS_ADDR_STATUS, 32'hFFFFFFFF);
    apb(0, `AFS_ADDR_STATUS, 0);
    chk(rd[15:0], {`AFS_FS_IDLE, 12'h000}, "status");
    apb(0, 12'h020, 0);
    chk({err, rd}, 33'h100000000, "unmapped");
    $display("test regs done");
  endtask
  task t_lamp;
    press(1, 40, 20);
    chk({trf_lamp, fn_lamp, rate_lamp, led, alarm}, 8'hFE, "lamps");
    repeat (40) @(posedge pclk);
    chk({trf_lamp, fn_lamp, rate_lamp, led, alarm}, 8'h00, "off");
    $display("test lamp done");
  endtask
  task t_traffic;
    trf <= 0;
    repeat (5) @(posedge pclk);
    trf <= 1;
    repeat (20) @(posedge pclk);
    chk(trf_lamp, 0, "blip");
    trf <= 0;
    wait_on(1, 1, 40, "trf lamp");
    @(posedge pclk);
    chk(alarm, 1, "trf alarm");
    press(1, 8, 30);
    chk({trf_lamp, alarm}, 2'b10, "trf ack");
    trf <= 1;
    repeat (20) @(posedge pclk);
    chk({trf_lamp, alarm}, 2'b01, "restored");
    press(1, 8, 30);
    chk(alarm, 0, "re-ack");
    $display("test traffic done");
  endtask
  task t_func;
    fault <= 4'h1;
    repeat (10) @(posedge pclk);
    fault <= 4'h0;
    repeat (30) @(posedge pclk);
    chk(led, 0, "fault blip");
    fault <= 4'h1;
    repeat (20) @(posedge pclk);
    chk(led, 0, "early");
    wait_on(2, 1, 20, "fn lamp");
    @(posedge pclk);
    chk({led, alarm}, 5'h03, "confirmed");
    apb(1, `AFS_ADDR_CTRL, 0);
    repeat (2) @(posedge pclk);
    chk(alarm, 0, "alarm disabled");
    apb(1, `AFS_ADDR_CTRL, 1);
    trf <= 0;
    wait_on(1, 1, 40, "trf lamp");
    repeat (3) @(posedge pclk);
    chk(fn_lamp, 0, "fn masked");
    trf <= 1;
    repeat (5) @(posedge pclk);
    chk({led, fn_lamp, alarm}, 6'h07, "restored");
    press(1, 8, 30);
    chk(alarm, 0, "fn ack");
    press(1, 8, 30);
    chk({led, fn_lamp, alarm}, 6'h06, "memory");
    fault <= 4'h0;
    wait_on(2, 0, 100, "fn clear");
    chk({led, trf_lamp, alarm}, 0, "quiet");
    $display("test functional done");
  endtask
  task t_scan;
    // Freeze away from the spare input so the stall point is plain
    apb(0, `AFS_ADDR_SCAN, 0);
    for (k = 0; k < 8 && (rd[2:0] == 0 || rd[2:0] > 3); k++)
      apb(0, `AFS_ADDR_SCAN, 0);
    frz <= 1;
    wait_on(0, 1, 100, "stall alarm");
    chk({fn_lamp, led[2]}, 2'b11, "stall led");
    press(1, 8, 30);
    chk({fn_lamp, alarm}, 2'b10, "silenced");
    apb(0, `AFS_ADDR_SCAN, 0);
    sel = rd[2:0] + 3'h1;
    press(1, 8, 10);
    wait_on(0, 1, 60, "resound");
    apb(0, `AFS_ADDR_SCAN, 0);
    chk(rd[2:0], sel, "stepped");
    press(1, 8, 30);
    chk({fn_lamp, alarm}, 2'b10, "silenced again");
    frz <= 0;
    press(1, 8, 30);
    wait_on(2, 0, 200, "scan clear");
    $display("test scan done");
  endtask
  task t_rate;
    cfg <= 36'h492FA52C2;
    k = n_asg;
    press(0, 8, 30);
    chk(code_asg, 36'h492FA52C2, "assigned");
    chk(n_asg, k + 1, "assign pulse");
    apb(0, `AFS_ADDR_RATE, 0);
    chk(rd[9:0], 10'h021, "rate sum");
    cfg <= 36'h492492DB6;
    repeat (4) @(posedge pclk);
    chk({rate_lamp, alarm}, 2'b10, "overload");
    press(0, 8, 30);
    chk(code_asg, 36'h492FA52C2, "inhibit");
    chk(n_asg, k + 1, "no pulse");
    apb(1, `AFS_ADDR_FSK, 32'h1);
    cfg <= 36'h492492495;
    fl = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge pclk);
      fl |= {rate_lamp, !rate_lamp};
    end
    chk({fl, alarm}, 3'b110, "flash");
    apb(0, `AFS_ADDR_RATE, 0);
    chk(rd[9], 1, "fsk bad");
    cfg <= 36'h492492490;
    repeat (4) @(posedge pclk);
    apb(0, `AFS_ADDR_RATE, 0);
    chk(rd[9:8], 0, "fsk tty");
    $display("test rate done");
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_lamp;
    t_traffic;
    t_func;
    t_scan;
    t_rate;
    wrap_up;
  end
endmodule
